// ==== verilog/rge_group_enable.v ====
// Regulator group enable, discharge, isolation ramp and scaling control
// Contract
// - Five groups: A, B core, C, D, E
// - Group E holds peripheral_buck_boost only under option one
// - Group on/off switches all members together
// - Gate supply needs no lockout, pin, off, fault
// - Boost output needs gate supply, no command, fault
// - Core regulators need gate regulation, no command, fault
// - Peripheral_buck_boost gated by both groups C and E
// - Boost isolation switch ramps on gradually
// - Boost output discharged while its group off
// - Regs two to eight discharged when off
// - Boost setpoint 2.5% steps within 10%
// - Buck-boost setpoints 2.5% steps, +17.5/-20%
// - Core buck coarse setting from scaling register
// - Core buck fine downward steps to 40%
// - Boost switches tristated when battery above output
// - Regulators one to five use primary clock
// - Output monitors feed group fault gating
// - Per-regulator choice: shut off or flag only
// - Core auto-off fault shuts device, restarts, holds reset
// - Core group retries once after 10 ms
// - Thermal limit shuts whole group
`include "rge_map.vh"
`default_nettype none
module rge_group_enable #(
  parameter RETRY_CYC = (`RGE_RETRY_MS * `RGE_CLK_KHZ),
  parameter RAMP_W    = `RGE_RAMP_W
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        uvlo_pin,
  input  wire        power_switch_pin,
  input  wire        batt_above_5v_pin,
  input  wire        gate_drive_reg_ok,
  input  wire        cmd_wr,
  input  wire        global_off_command,
  input  wire [4:0]  group_off_cmd,
  input  wire        alt_seq_option1,
  input  wire [7:0]  ovuv_auto_off,
  input  wire [7:0]  ovuv_fault,
  input  wire [7:0]  short_fault,
  input  wire [7:0]  thermal_fault,
  input  wire        dvs_wr,
  input  wire [3:0]  dvs_boost,
  input  wire [3:0]  dvs_buck_boost_a,
  input  wire [3:0]  dvs_core_buck,
  input  wire [6:0]  dvs_core_buck_fine,
  input  wire [3:0]  dvs_buck_boost_b,
  input  wire [3:0]  dvs_peripheral,
  output reg         gate_drive_supply_en,
  output reg  [7:0]  reg_en,
  output reg  [7:0]  discharge_en,
  output reg  [7:0]  iso_ramp,
  output reg         boost_tristate,
  output reg  [7:0]  primary_switch_freq_sel,
  output reg  [7:0]  ovuv_flag,
  output reg         core_reset_n,
  output reg  [3:0]  boost_dvs_code,
  output reg  [3:0]  buck_boost_a_dvs_code,
  output reg  [3:0]  core_buck_dvs_code,
  output reg  [6:0]  core_buck_fine_code,
  output reg  [3:0]  buck_boost_b_dvs_code,
  output reg  [3:0]  peripheral_dvs_code
);

////////////////////////////////////////////////////////////////////////////////
// Helpers
function [3:0] rge_clamp;
  input [3:0] v;
  input [3:0] hi;
  begin
    rge_clamp = (v > hi) ? hi : v;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, change accepted when stages two and three agree
reg [2:0] uvlo_sync_reg;
reg [2:0] sw_sync_reg;
reg [2:0] batt_sync_reg;
reg       uvlo_reg;
reg       sw_reg;
reg       batt_reg;

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    uvlo_sync_reg <= 3'h7;
    sw_sync_reg   <= 3'h7;
    batt_sync_reg <= 3'h0;
    uvlo_reg      <= 1'b1;
    sw_reg        <= 1'b1;
    batt_reg      <= 1'b0;
  end else begin
    uvlo_sync_reg <= {uvlo_sync_reg[1:0], uvlo_pin};
    sw_sync_reg   <= {sw_sync_reg[1:0], power_switch_pin};
    batt_sync_reg <= {batt_sync_reg[1:0], batt_above_5v_pin};
    if (uvlo_sync_reg[1] == uvlo_sync_reg[2])
      uvlo_reg <= uvlo_sync_reg[2];
    if (sw_sync_reg[1] == sw_sync_reg[2])
      sw_reg <= sw_sync_reg[2];
    if (batt_sync_reg[1] == batt_sync_reg[2])
      batt_reg <= batt_sync_reg[2];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Stored commands and fault latches
reg        off_reg;
reg [4:0]  grp_off_reg;
reg [7:0]  trip_reg;
reg [7:0]  trip_next;
reg [7:0]  flag_next;
reg        core_sc_reg;
reg        retried_reg;
reg [31:0] retry_cnt_reg;
wire       retry_done = (retry_cnt_reg == RETRY_CYC - 1);
wire [7:0] ovuv_trip  = ovuv_fault & ovuv_auto_off;
wire       core_ovuv  = |ovuv_trip[`RGE_R4:`RGE_R2];
wire       core_therm = |thermal_fault[`RGE_R4:`RGE_R2];
wire       dev_fault  = core_ovuv | core_therm | (core_sc_reg & retried_reg);
wire       gate_ok    = ~uvlo_reg & sw_reg & ~off_reg & ~dev_fault;
wire       gate_reg_ok = gate_ok & gate_drive_reg_ok;

// Group membership
wire grp_a_fault = trip_reg[`RGE_R1] | thermal_fault[`RGE_R1];
wire grp_b_fault = |trip_reg[`RGE_R4:`RGE_R2] | core_sc_reg | core_therm;
wire grp_c_fault = |trip_reg[`RGE_R7:`RGE_R5] | |thermal_fault[`RGE_R7:`RGE_R5];
wire grp_d_fault = trip_reg[`RGE_R8] | thermal_fault[`RGE_R8];
wire grp_e_fault = alt_seq_option1 & (trip_reg[`RGE_R5] | thermal_fault[`RGE_R5]);
wire grp_e_off   = alt_seq_option1 & grp_off_reg[`RGE_GRP_E];

wire on_a = gate_ok & ~grp_off_reg[`RGE_GRP_A] & ~grp_a_fault;
wire on_b = gate_reg_ok & ~grp_off_reg[`RGE_GRP_B] & ~grp_b_fault;
wire on_c = gate_reg_ok & ~grp_off_reg[`RGE_GRP_C] & ~grp_c_fault;
wire on_5 = on_c & ~grp_e_off & ~grp_e_fault;
wire on_d = gate_reg_ok & ~grp_off_reg[`RGE_GRP_D] & ~grp_d_fault;
wire [7:0] en_next = {on_d, on_c, on_c, on_5, on_b, on_b, on_b, on_a};

always @* begin
  trip_next = trip_reg;
  flag_next = ovuv_flag | ovuv_fault;
  if (cmd_wr)
    flag_next = ovuv_fault;
  trip_next = (trip_reg | ovuv_trip | short_fault) & ~(cmd_wr ? ~ovuv_trip : 8'h00);
  trip_next[`RGE_R4:`RGE_R2] = ovuv_trip[`RGE_R4:`RGE_R2];
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    off_reg       <= 1'b0;
    grp_off_reg   <= 5'h00;
    trip_reg      <= 8'h00;
    ovuv_flag     <= 8'h00;
    core_sc_reg   <= 1'b0;
    retried_reg   <= 1'b0;
    retry_cnt_reg <= 32'h0;
  end else begin
    if (cmd_wr) begin
      off_reg     <= global_off_command;
      grp_off_reg <= group_off_cmd;
    end
    trip_reg  <= trip_next;
    ovuv_flag <= flag_next;
    if (|short_fault[`RGE_R4:`RGE_R2] & ~core_sc_reg) begin
      core_sc_reg   <= 1'b1;
      retry_cnt_reg <= 32'h0;
    end else if (core_sc_reg & ~retried_reg) begin
      if (retry_done) begin
        core_sc_reg   <= 1'b0;
        retried_reg   <= 1'b1;
        retry_cnt_reg <= 32'h0;
      end else begin
        retry_cnt_reg <= retry_cnt_reg + 32'h1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Enables, discharge, ramp, clock select, reset
reg [RAMP_W-1:0] ramp_reg;
wire             ramp_full = &ramp_reg;

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    gate_drive_supply_en    <= 1'b0;
    reg_en                  <= 8'h00;
    discharge_en            <= 8'hff;
    iso_ramp                <= 8'h00;
    ramp_reg                <= {RAMP_W{1'b0}};
    boost_tristate          <= 1'b0;
    primary_switch_freq_sel <= 8'h00;
    core_reset_n            <= 1'b0;
  end else begin
    gate_drive_supply_en <= gate_ok;
    reg_en               <= en_next;
    discharge_en         <= ~en_next;
    if (!on_a)
      ramp_reg <= {RAMP_W{1'b0}};
    else if (!ramp_full)
      ramp_reg <= ramp_reg + {{(RAMP_W-1){1'b0}}, 1'b1};
    iso_ramp       <= ramp_reg[RAMP_W-1 -: 8];
    boost_tristate <= batt_reg & on_a;
    primary_switch_freq_sel <= 8'h1f;
    core_reset_n   <= on_b & gate_drive_reg_ok;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Dynamic voltage scaling codes
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    boost_dvs_code        <= `RGE_DVS10_MIN;
    buck_boost_a_dvs_code <= `RGE_DVS_MIN;
    core_buck_dvs_code    <= `RGE_DVS_MIN;
    core_buck_fine_code   <= 7'h00;
    buck_boost_b_dvs_code <= `RGE_DVS_MIN;
    peripheral_dvs_code   <= `RGE_DVS_MIN;
  end else if (dvs_wr) begin
    boost_dvs_code        <= rge_clamp(dvs_boost, `RGE_DVS10_MAX);
    buck_boost_a_dvs_code <= rge_clamp(dvs_buck_boost_a, `RGE_DVS_MAX);
    core_buck_dvs_code    <= rge_clamp(dvs_core_buck, `RGE_DVS_MAX);
    core_buck_fine_code   <= (dvs_core_buck_fine > `RGE_FINE_MAX) ?
                             `RGE_FINE_MAX : dvs_core_buck_fine;
    buck_boost_b_dvs_code <= rge_clamp(dvs_buck_boost_b, `RGE_DVS_MAX);
    peripheral_dvs_code   <= rge_clamp(dvs_peripheral, `RGE_DVS_MAX);
  end
end

endmodule // rge_group_enable
`default_nettype wire

// ==== verilog/rge_map.vh ====
// Constants for the regulator group enable block
`ifndef RGE_MAP_VH
`define RGE_MAP_VH
`define RGE_NREG          8
`define RGE_R1            0
`define RGE_R2            1
`define RGE_R3            2
`define RGE_R4            3
`define RGE_R5            4
`define RGE_R6            5
`define RGE_R7            6
`define RGE_R8            7
`define RGE_GRP_A         0
`define RGE_GRP_B         1
`define RGE_GRP_C         2
`define RGE_GRP_D         3
`define RGE_GRP_E         4
`define RGE_RETRY_MS      10
`define RGE_CLK_KHZ       50000
`define RGE_RAMP_W        8
`define RGE_RAMP_FULL     8'hff
`define RGE_DVS10_MIN     4'h0
`define RGE_DVS10_MAX     4'h8
`define RGE_DVS_MIN       4'h0
`define RGE_DVS_MAX       4'hf
`define RGE_FINE_MAX      7'h78
`endif

// ==== dv/rge_host.sv ====
// Host model that writes the stored off commands of the enable block
`default_nettype none
module rge_host (
  input  wire logic       mclk,
  output var  logic       cmd_wr,
  output var  logic       global_off_command,
  output var  logic [4:0] group_off_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmd_wr, global_off_command, group_off_cmd} = 7'h00;
  // One write pulse, then the bus shows the inverse so only stored bits can count
  task automatic send(input logic off, input logic [4:0] grp);
    @(posedge mclk);
    {cmd_wr, global_off_command, group_off_cmd} <= {1'b1, off, grp};
    @(posedge mclk);
    {cmd_wr, global_off_command, group_off_cmd} <= {1'b0, ~off, ~grp};
  endtask
endmodule // rge_host
`default_nettype wire

// ==== dv/rge_group_enable_sva.sv ====
// Assertion checker for the regulator group enable block
`default_nettype none
module rge_sva (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       cmd_wr,
  input wire logic       global_off_command,
  input wire logic [4:0] group_off_cmd,
  input wire logic       alt_seq_option1,
  input wire logic       batt_above_5v_pin,
  input wire logic [7:0] thermal_fault,
  input wire logic       gate_drive_supply_en,
  input wire logic [7:0] reg_en,
  input wire logic [7:0] discharge_en,
  input wire logic       boost_tristate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_gate_off: assert property (cmd_wr && global_off_command |-> ##2 !gate_drive_supply_en) else $error("gate on");
  a_boost_off: assert property (cmd_wr && group_off_cmd[0] |-> ##2 !reg_en[0]) else $error("boost on");
  a_core_off: assert property (cmd_wr && group_off_cmd[1] |-> ##2 reg_en[3:1] == 3'b000) else $error("core on");
  a_peripheral_buck_boost_grp_c: assert property (cmd_wr && group_off_cmd[2] |-> ##2 reg_en[6:4] == 3'b000) else $error("c on");
  a_peripheral_buck_boost_grp_e: assert property (cmd_wr && group_off_cmd[4] && alt_seq_option1 |-> ##2 !reg_en[4])
    else $error("peripheral_buck_boost on");
  a_discharge_inv: assert property (discharge_en == ~reg_en) else $error("discharge wrong");
  a_thermal_grp: assert property (thermal_fault[7] |-> ##1 !reg_en[7]) else $error("thermal ignored");
  a_boost_tri: assert property (batt_above_5v_pin [*8] ##0 reg_en[0] |-> boost_tristate) else $error("not tristated");
endmodule // rge_sva
bind rge_group_enable rge_sva u_sva (.mclk, .rst, .cmd_wr, .global_off_command, .group_off_cmd, .alt_seq_option1,
  .batt_above_5v_pin, .thermal_fault, .gate_drive_supply_en, .reg_en, .discharge_en, .boost_tristate);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking testbench for the regulator group enable block
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin errors++; $display("mismatch %0t %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rst, uvlo_pin, power_switch_pin, batt_above_5v_pin, alt_seq_option1, dvs_wr;
  logic [7:0] thermal_fault, ovuv_fault, short_fault;
  wire  [7:0] ovuv_flag;
  wire        core_reset_n;
  logic [3:0] dvs_boost, dvs_bb, dvs_core;
  logic [6:0] dvs_fine;
  wire        cmd_wr, global_off_command, gate_drive_supply_en, boost_tristate;
  wire  [4:0] group_off_cmd;
  wire  [7:0] reg_en, discharge_en, iso_ramp, freq_sel;
  wire  [3:0] c_boost, c_bba, c_core;
  wire  [6:0] c_fine;
  int         errors = 0;
  int         num_checks = 0;
  logic [7:0] mask [5] = '{8'hfe, 8'hf1, 8'h8f, 8'h7f, 8'hef};
  rge_host host (.mclk, .cmd_wr, .global_off_command, .group_off_cmd);
  rge_group_enable #(.RETRY_CYC(20)) dut (.mclk, .rst, .uvlo_pin, .power_switch_pin, .batt_above_5v_pin,
    .gate_drive_reg_ok(1'b1), .cmd_wr, .global_off_command, .group_off_cmd, .alt_seq_option1, .thermal_fault,
    .ovuv_auto_off(8'h80), .ovuv_fault, .short_fault, .dvs_wr, .dvs_boost, .dvs_buck_boost_a(dvs_bb),
    .dvs_core_buck(dvs_core), .dvs_core_buck_fine(dvs_fine), .dvs_buck_boost_b(dvs_bb), .dvs_peripheral(dvs_bb),
    .gate_drive_supply_en, .reg_en, .discharge_en, .iso_ramp, .boost_tristate, .primary_switch_freq_sel(freq_sel),
    .ovuv_flag, .core_reset_n, .boost_dvs_code(c_boost), .buck_boost_a_dvs_code(c_bba),
    .core_buck_dvs_code(c_core), .core_buck_fine_code(c_fine), .buck_boost_b_dvs_code(), .peripheral_dvs_code());
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #60us;
    errors++;
    complete_run();
  end
  initial begin
    {rst, uvlo_pin, power_switch_pin, batt_above_5v_pin, alt_seq_option1, dvs_wr} = 6'b101010;
    {thermal_fault, ovuv_fault, short_fault, dvs_boost, dvs_bb, dvs_core, dvs_fine} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    tick(10);
    `CHK({gate_drive_supply_en, reg_en, discharge_en, freq_sel}, {1'b1, 8'hff, 8'h00, 8'h1f}, "reset")
    `CHK(core_reset_n, 1'b1, "core reset")
    for (int g = 0; g < 6; g++) begin
      @(posedge mclk);
      alt_seq_option1 <= (g < 5);
      host.send(1'b0, 5'h01 << (g < 5 ? g : 4));
      tick(2);
      `CHK({reg_en, discharge_en}, g < 5 ? {mask[g], ~mask[g]} : 16'hff00, "group")
    end
    host.send(1'b1, 5'h00);
    tick(3);
    `CHK({gate_drive_supply_en, reg_en}, 9'h000, "all off")
    host.send(1'b0, 5'h00);
    tick(3);
    `CHK(iso_ramp < 8'h10, 1'b1, "ramp start")
    tick(260);
    `CHK(iso_ramp, 8'hff, "ramp end")
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      {uvlo_pin, power_switch_pin} <= i ? 2'b00 : 2'b11;
      tick(10);
      `CHK({gate_drive_supply_en, reg_en}, 9'h000, "pin off")
      @(posedge mclk);
      {uvlo_pin, power_switch_pin} <= 2'b01;
      tick(10);
      `CHK(gate_drive_supply_en, 1'b1, "pin on")
    end
    @(posedge mclk);
    {thermal_fault, batt_above_5v_pin, dvs_wr} <= {8'h80, 2'b11};
    {dvs_boost, dvs_bb, dvs_core, dvs_fine} <= {4'hf, 4'hf, 4'hf, 7'h7f};
    @(posedge mclk);
    dvs_wr <= 1'b0;
    tick(10);
    `CHK({reg_en, boost_tristate}, {8'h7f, 1'b1}, "trip")
    `CHK({c_boost, c_bba, c_core, c_fine}, {4'h8, 4'hf, 4'hf, 7'h78}, "dvs")
    @(posedge mclk);
    {thermal_fault, batt_above_5v_pin, ovuv_fault} <= {8'h00, 1'b0, 8'h80};
    @(posedge mclk);
    ovuv_fault <= 8'h00;
    tick(2);
    `CHK({reg_en, ovuv_flag}, 16'h7f80, "ovuv trip")
    host.send(1'b0, 5'h00);
    tick(2);
    `CHK({reg_en, ovuv_flag}, 16'hff00, "ovuv clear")
    @(posedge mclk);
    short_fault <= 8'h04;
    @(posedge mclk);
    short_fault <= 8'h00;
    tick(2);
    `CHK(reg_en, 8'hf1, "short off")
    tick(25);
    `CHK(reg_en, 8'hff, "short retry")
    @(posedge mclk);
    short_fault <= 8'h04;
    @(posedge mclk);
    short_fault <= 8'h00;
    tick(30);
    `CHK({gate_drive_supply_en, reg_en, core_reset_n}, 10'h000, "short latch")
    @(posedge mclk);
    rst <= 1'b1;
    tick(2);
    @(posedge mclk);
    rst <= 1'b0;
    tick(10);
    `CHK({gate_drive_supply_en, reg_en, core_reset_n}, 10'h3ff, "reset again")
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
